// >>> hdl/snb_defines.svh
// Constants for the serial NAND bus interface
`ifndef SNB_DEFINES_SVH
`define SNB_DEFINES_SVH

// -------------------------------------------------------------
// Byte framing
// -------------------------------------------------------------
`define SNB_BYTE_BITS        4'h8
`define SNB_IDLE_BYTE        8'hFF
`define SNB_FIFO_DEPTH       8
`define SNB_FIFO_WIDTH       8

// -------------------------------------------------------------
// Block lock register layout and reset value
// -------------------------------------------------------------
`define SNB_LOCK_RESET       8'h7C
`define SNB_LOCK_WD_BIT      7
`define SNB_LOCK_PINDIS_BIT  1
`define SNB_LOCK_KEEP_MSB    7
`define SNB_LOCK_KEEP_LSB    2

// -------------------------------------------------------------
// Security configuration and legacy read commands
// -------------------------------------------------------------
`define SNB_CFG_NOR_READ     3'h5
`define SNB_CMD_READ_SLOW    8'h03
`define SNB_CMD_READ_FAST    8'h0B

// -------------------------------------------------------------
// Synchroniser slot order
// -------------------------------------------------------------
`define SNB_SYNC_COUNT       6
`define SNB_SYNC_SCLK        0
`define SNB_SYNC_CSN         1
`define SNB_SYNC_LINE0       2
`define SNB_SYNC_LINE1       3
`define SNB_SYNC_LINE2       4
`define SNB_SYNC_LINE3       5

`endif

// >>> hdl/snb_pkg.sv
// Types shared by the serial NAND bus interface
`default_nettype none

package snb_pkg;

    // ---------------------------------------------------------
    // Data line configuration
    // ---------------------------------------------------------
    typedef enum logic [1:0] {
        SNB_LANE_SINGLE = 2'b00,
        SNB_LANE_DUAL   = 2'b01,
        SNB_LANE_QUAD   = 2'b10
    } snb_lane_t;

    // ---------------------------------------------------------
    // Interface state
    // ---------------------------------------------------------
    typedef enum logic [1:0] {
        SNB_ST_IDLE   = 2'b00,
        SNB_ST_ACTIVE = 2'b01,
        SNB_ST_HOLD   = 2'b10
    } snb_state_t;

endpackage

`default_nettype wire

// >>> hdl/snb_fifo.sv
// Receive byte FIFO with valid and ready on both sides
`default_nettype none

module snb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clkEnable,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrIdx;
    logic [PW-1:0]    rdIdx;
    logic [CW-1:0]    count;
    logic             doPush;
    logic             doPop;

    assign inReady  = (count != CW'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdIdx];
    assign doPush   = clkEnable && inValid && inReady;
    assign doPop    = clkEnable && outValid && outReady;

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrIdx] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrIdx <= '0;
            rdIdx <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrIdx <= (wrIdx == PW'(DEPTH - 1)) ? '0 : wrIdx + 1'b1;
            end
            if (doPop) begin
                rdIdx <= (rdIdx == PW'(DEPTH - 1)) ? '0 : rdIdx + 1'b1;
            end
            if (doPush && !doPop) begin
                count <= count + 1'b1;
            end else if (doPop && !doPush) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> hdl/snb_bus_interface.sv
// Serial bus front end of a serial NAND flash device
`include "snb_defines.svh"
`default_nettype none

module snb_bus_interface (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              clkEnable,
    // Serial pins
    input  wire logic              chipSelN,
    input  wire logic              serialClk,
    input  wire logic              line0In,
    output logic                   line0Out,
    output logic                   line0OeN,
    input  wire logic              line1In,
    output logic                   line1Out,
    output logic                   line1OeN,
    input  wire logic              line2In,
    output logic                   line2Out,
    output logic                   line2OeN,
    input  wire logic              line3In,
    output logic                   line3Out,
    output logic                   line3OeN,
    // Configuration
    input  wire snb_pkg::snb_lane_t laneMode,
    input  wire logic              pauseEnable,
    input  wire logic [2:0]        securityCfg,
    input  wire logic              internalBusy,
    // Block lock register access
    input  wire logic              lockWrEn,
    input  wire logic [7:0]        lockWrData,
    output logic [7:0]             lockReg,
    output logic                   lockFrozen,
    // Received bytes
    output logic [7:0]             rxData,
    output logic                   rxValid,
    input  wire logic              rxReady,
    output logic                   rxOverrun,
    // Transmit bytes
    input  wire logic              txEnable,
    input  wire logic [7:0]        txData,
    input  wire logic              txValid,
    output logic                   txTaken,
    // Status
    output logic                   selected,
    output logic                   standby,
    output logic                   paused,
    output logic                   norReadMode,
    output logic                   norReadCmd
);
    import snb_pkg::*;

    // ---------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------
    function automatic logic [3:0] laneWidth(input snb_lane_t m);
        case (m)
            SNB_LANE_DUAL: laneWidth = 4'h2;
            SNB_LANE_QUAD: laneWidth = 4'h4;
            default:       laneWidth = 4'h1;
        endcase
    endfunction

    // ---------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------
    logic [`SNB_SYNC_COUNT-1:0] rawIn;
    logic [`SNB_SYNC_COUNT-1:0] syncA;
    logic [`SNB_SYNC_COUNT-1:0] syncB;

    assign rawIn = {line3In, line2In, line1In, line0In, chipSelN,
                    serialClk};

    genvar gi;
    generate
        for (gi = 0; gi < `SNB_SYNC_COUNT; gi++) begin : gSync
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    syncA[gi] <= 1'b1;
                    syncB[gi] <= 1'b1;
                end else if (clkEnable) begin
                    syncA[gi] <= rawIn[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------
    // Edge detection and pause decode
    // ---------------------------------------------------------
    snb_state_t state;
    snb_state_t next_state;
    logic       sclkPrev;
    logic       pausePrev;
    logic       sclkS;
    logic       selS;
    logic       quad;
    logic       pauseEff;
    logic       sclkRise;
    logic       sclkFall;
    logic       holdEnter;
    logic       holdExit;

    assign sclkS    = syncB[`SNB_SYNC_SCLK];
    assign selS     = !syncB[`SNB_SYNC_CSN];
    assign quad     = (laneMode == SNB_LANE_QUAD);
    // Pause pin only counts when the option is present, not in quad
    assign pauseEff = (pauseEnable && !quad)
                      ? syncB[`SNB_SYNC_LINE3] : 1'b1;
    assign sclkRise = sclkS && !sclkPrev;
    assign sclkFall = !sclkS && sclkPrev;
    assign holdEnter = (pausePrev && !pauseEff && !sclkS)
                       || (sclkFall && !pauseEff);
    assign holdExit  = (!pausePrev && pauseEff && !sclkS)
                       || (sclkFall && pauseEff);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // Matches the synchroniser reset so no false edge follows
            sclkPrev  <= 1'b1;
            pausePrev <= 1'b1;
        end else if (clkEnable) begin
            sclkPrev  <= sclkS;
            pausePrev <= pauseEff;
        end
    end

    // ---------------------------------------------------------
    // Interface state machine
    // ---------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            SNB_ST_IDLE: begin
                if (selS) begin
                    next_state = SNB_ST_ACTIVE;
                end
            end
            SNB_ST_ACTIVE: begin
                if (!selS) begin
                    next_state = SNB_ST_IDLE;
                end else if (holdEnter) begin
                    next_state = SNB_ST_HOLD;
                end
            end
            SNB_ST_HOLD: begin
                if (!selS) begin
                    next_state = SNB_ST_IDLE;
                end else if (holdExit) begin
                    next_state = SNB_ST_ACTIVE;
                end
            end
            default: next_state = SNB_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= SNB_ST_IDLE;
        end else if (clkEnable) begin
            state <= next_state;
        end
    end

    // Clock edges only count while active and not entering pause
    logic shiftGo;
    logic driveGo;
    assign shiftGo = (state == SNB_ST_ACTIVE) && selS
                     && !holdEnter && sclkRise;
    assign driveGo = (state == SNB_ST_ACTIVE) && selS
                     && !holdEnter && sclkFall;

    // ---------------------------------------------------------
    // Receive shifter
    // ---------------------------------------------------------
    logic       firstByte;
    logic [3:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] next_rxShift;
    logic [3:0] rxWidth;
    logic       byteDone;
    logic [7:0] pendByte;
    logic       pendValid;
    logic       fifoReady;

    // The command byte always travels on line 0 alone
    assign rxWidth  = firstByte ? 4'h1 : laneWidth(laneMode);
    assign byteDone = shiftGo && (bitCnt + rxWidth == `SNB_BYTE_BITS);

    always_comb begin
        case (rxWidth)
            4'h2:    next_rxShift = {rxShift[5:0],
                         syncB[`SNB_SYNC_LINE1], syncB[`SNB_SYNC_LINE0]};
            4'h4:    next_rxShift = {rxShift[3:0],
                         syncB[`SNB_SYNC_LINE3], syncB[`SNB_SYNC_LINE2],
                         syncB[`SNB_SYNC_LINE1], syncB[`SNB_SYNC_LINE0]};
            default: next_rxShift = {rxShift[6:0],
                         syncB[`SNB_SYNC_LINE0]};
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            firstByte <= 1'b1;
            bitCnt    <= 4'h0;
            rxShift   <= 8'h00;
        end else if (clkEnable) begin
            if (!selS) begin
                firstByte <= 1'b1;
                bitCnt    <= 4'h0;
            end else if (shiftGo) begin
                rxShift <= next_rxShift;
                if (byteDone) begin
                    bitCnt    <= 4'h0;
                    firstByte <= 1'b0;
                end else begin
                    bitCnt <= bitCnt + rxWidth;
                end
            end
        end
    end

    // Completed bytes wait here until the FIFO takes them
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pendValid <= 1'b0;
            pendByte  <= 8'h00;
            rxOverrun <= 1'b0;
        end else if (clkEnable) begin
            if (byteDone) begin
                pendValid <= 1'b1;
                pendByte  <= next_rxShift;
                if (pendValid && !fifoReady) begin
                    rxOverrun <= 1'b1;
                end
            end else if (fifoReady) begin
                pendValid <= 1'b0;
            end
            if (!selS && !byteDone) begin
                rxOverrun <= 1'b0;
            end
        end
    end

    snb_fifo #(
        .WIDTH (`SNB_FIFO_WIDTH),
        .DEPTH (`SNB_FIFO_DEPTH)
    ) uRxFifo (
        .clk       (sys_clk),
        .reset     (reset),
        .clkEnable (clkEnable),
        .inData    (pendByte),
        .inValid   (pendValid),
        .inReady   (fifoReady),
        .outData   (rxData),
        .outValid  (rxValid),
        .outReady  (rxReady)
    );

    // ---------------------------------------------------------
    // Legacy read command recognition
    // ---------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            norReadMode <= 1'b0;
            norReadCmd  <= 1'b0;
        end else if (clkEnable) begin
            norReadMode <= (securityCfg == `SNB_CFG_NOR_READ);
            norReadCmd  <= byteDone && firstByte && norReadMode
                && (next_rxShift == `SNB_CMD_READ_SLOW
                    || next_rxShift == `SNB_CMD_READ_FAST);
        end
    end

    // ---------------------------------------------------------
    // Transmit shifter and line drivers
    // ---------------------------------------------------------
    logic [7:0] txShift;
    logic [3:0] txCnt;
    logic [3:0] txWidth;
    logic [7:0] txWord;
    logic [3:0] outBits;
    logic       txStarted;
    logic       driving;

    assign txWidth = laneWidth(laneMode);
    assign txWord  = (txCnt == 4'h0)
                     ? (txValid ? txData : `SNB_IDLE_BYTE) : txShift;
    assign driving = txStarted && txEnable && selS
                     && (state == SNB_ST_ACTIVE);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txShift   <= 8'h00;
            txCnt     <= 4'h0;
            outBits   <= 4'h0;
            txStarted <= 1'b0;
            txTaken   <= 1'b0;
        end else if (clkEnable) begin
            txTaken <= 1'b0;
            if (!selS || !txEnable) begin
                txCnt     <= 4'h0;
                txStarted <= 1'b0;
            end else if (driveGo) begin
                txStarted <= 1'b1;
                txTaken   <= (txCnt == 4'h0) && txValid;
                case (txWidth)
                    4'h2:    outBits <= {2'b00, txWord[7:6]};
                    4'h4:    outBits <= txWord[7:4];
                    default: outBits <= {2'b00, 1'b0, txWord[7]};
                endcase
                txShift <= 8'(txWord << txWidth);
                txCnt   <= (txCnt == 4'h0)
                           ? `SNB_BYTE_BITS - txWidth : txCnt - txWidth;
            end
        end
    end

    // Output enables are low while the line is driven
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            line0Out <= 1'b0;
            line1Out <= 1'b0;
            line2Out <= 1'b0;
            line3Out <= 1'b0;
            line0OeN <= 1'b1;
            line1OeN <= 1'b1;
            line2OeN <= 1'b1;
            line3OeN <= 1'b1;
        end else if (clkEnable) begin
            case (txWidth)
                4'h4: begin
                    {line3Out, line2Out, line1Out, line0Out} <= outBits;
                end
                4'h2: begin
                    {line1Out, line0Out} <= outBits[1:0];
                end
                default: begin
                    line1Out <= outBits[0];
                end
            endcase
            line1OeN <= !driving;
            line0OeN <= !(driving && txWidth != 4'h1);
            line2OeN <= !(driving && quad);
            line3OeN <= !(driving && quad);
        end
    end

    // ---------------------------------------------------------
    // Block lock register
    // ---------------------------------------------------------
    logic wpLow;
    logic freezeNow;
    assign wpLow     = !syncB[`SNB_SYNC_LINE2] && !quad;
    assign freezeNow = !lockReg[`SNB_LOCK_PINDIS_BIT]
                       && lockReg[`SNB_LOCK_WD_BIT] && wpLow;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lockReg    <= `SNB_LOCK_RESET;
            lockFrozen <= 1'b0;
        end else if (clkEnable) begin
            lockFrozen <= freezeNow;
            if (lockWrEn) begin
                lockReg[0] <= 1'b0;
                lockReg[`SNB_LOCK_PINDIS_BIT] <=
                    lockWrData[`SNB_LOCK_PINDIS_BIT];
                if (!freezeNow) begin
                    lockReg[`SNB_LOCK_KEEP_MSB:`SNB_LOCK_KEEP_LSB] <=
                        lockWrData[`SNB_LOCK_KEEP_MSB:`SNB_LOCK_KEEP_LSB];
                end
            end
        end
    end

    // ---------------------------------------------------------
    // Status outputs
    // ---------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            selected <= 1'b0;
            standby  <= 1'b1;
            paused   <= 1'b0;
        end else if (clkEnable) begin
            selected <= selS;
            standby  <= !selS && !internalBusy;
            paused   <= (next_state == SNB_ST_HOLD);
        end
    end

endmodule

`default_nettype wire

// >>> testbench/snb_bus_interface_assertions.sv
// Port checks for the serial NAND bus interface
`default_nettype none
module snb_bus_interface_assertions (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic              clkEnable,
    // Pins and controls
    input wire logic              chipSelN,
    input wire logic              line0OeN,
    input wire logic              line1OeN,
    input wire logic              line2OeN,
    input wire logic              line3OeN,
    input wire snb_pkg::snb_lane_t laneMode,
    input wire logic              pauseEnable,
    input wire logic              internalBusy,
    input wire logic              lockWrEn,
    input wire logic [7:0]        lockWrData,
    input wire logic [7:0]        lockReg,
    input wire logic              lockFrozen,
    // Status
    input wire logic              selected,
    input wire logic              standby,
    input wire logic              paused,
    input wire logic              norReadMode,
    input wire logic              norReadCmd
);
    import snb_pkg::*;
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    sequence csHigh;
        chipSelN [*5];
    endsequence
    sequence csLow;
        !chipSelN [*5];
    endsequence
    chk_desel_float: assert property (
        csHigh |-> line0OeN && line1OeN && line2OeN && line3OeN)
        else $error("line driven while deselected");
    chk_desel_state: assert property (
        csHigh |-> !selected && !paused)
        else $error("selected or paused while deselected");
    chk_sel_state: assert property (
        csLow |-> selected)
        else $error("not selected with chip select low");
    chk_standby_idle: assert property (
        (chipSelN && !internalBusy) [*5] |-> standby)
        else $error("no standby while idle");
    chk_pause_float: assert property (
        paused ##1 paused |-> line0OeN && line1OeN && line3OeN)
        else $error("line driven while paused");
    chk_pause_off: assert property (
        (laneMode == SNB_LANE_QUAD || !pauseEnable) [*3] |-> !paused)
        else $error("pause without pause function");
    chk_lock_frozen: assert property (
        lockWrEn && lockFrozen |=> $stable(lockReg[7:2]))
        else $error("frozen lock bits changed");
    chk_lock_write: assert property (
        lockWrEn && !lockFrozen && clkEnable |=>
        lockReg == {$past(lockWrData[7:1]), 1'h0})
        else $error("lock write lost");
    chk_nor_cmd: assert property (
        norReadCmd |-> norReadMode)
        else $error("legacy command outside legacy mode");
endmodule
`default_nettype wire

// >>> testbench/snb_host_model.sv
// Host serial controller model for the flash pins
`default_nettype none
module snb_host_model (
    // Clock
    input wire logic       sys_clk,
    // Pins
    output logic           csN,
    output logic           sclk,
    output logic [3:0]     dOut,
    output logic [3:0]     dOeN,
    input wire logic [3:0] dIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cpol = 1'h0;
    initial begin
        csN = 1'h1;
        sclk = 1'h0;
        dOut = 4'h0;
        dOeN = 4'hF;
    end
    // Half a serial clock: 400 ns
    task automatic half();
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic select(input logic pol);
        cpol = pol;
        sclk <= pol;
        half();
        csN <= 1'h0;
        half();
    endtask
    task automatic deselect();
        sclk <= cpol;
        half();
        csN <= 1'h1;
        dOeN <= 4'hF;
        half();
    endtask
    // Reply is read late in the high phase to cover sync latency
    task automatic xfer(input logic [7:0] tx, input int w,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 8 - w; i >= 0; i -= w) begin
            sclk <= 1'h0;
            dOeN <= w == 4 ? 4'h0 : (w == 2 ? 4'hC : 4'hE);
            dOut <= 4'(tx >> i);
            half();
            sclk <= 1'h1;
            half();
            rx = {rx[6:0], dIn[1]};
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Testbench for the serial NAND bus interface
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import snb_pkg::*;
    logic       sys_clk = 1'h0, reset = 1'h1, flip = 1'h0;
    logic       wpN = 1'h1, holdN = 1'h1, pauseEnable = 1'h0;
    logic       internalBusy = 1'h0, lockWrEn = 1'h0, rxReady = 1'h0;
    logic       txEnable = 1'h0, txValid = 1'h1, clkEnable = 1'h1;
    logic [2:0] securityCfg = 3'h0;
    logic [7:0] lockWrData = 8'h00, txData = 8'hC3, r;
    logic [7:0] cmds [2] = '{8'h03, 8'h0B};
    snb_lane_t  laneMode = SNB_LANE_SINGLE;
    int         error_cnt = 0, checked = 0, norCnt = 0, tkCnt = 0;
    wire  [3:0] dOut, dOeN, hOut, hOeN, pin;
    wire  [7:0] lockReg, rxData;
    wire        csN, sclk, lockFrozen, rxValid, rxOverrun, selected;
    wire        standby, paused, norReadMode, norReadCmd, txTaken;
    // Released lines 2 and 3 follow the wpN and holdN straps, others wander
    assign pin = ~dOeN & dOut | ~hOeN & hOut
               | dOeN & hOeN & {holdN, wpN, flip, ~flip};
    snb_host_model host (.sys_clk, .csN, .sclk, .dOut(hOut),
        .dOeN(hOeN), .dIn(pin));
    snb_bus_interface dut (.*, .chipSelN(csN),
        .serialClk(sclk),
        .line0In(pin[0]), .line0Out(dOut[0]), .line0OeN(dOeN[0]),
        .line1In(pin[1]), .line1Out(dOut[1]), .line1OeN(dOeN[1]),
        .line2In(pin[2]), .line2Out(dOut[2]), .line2OeN(dOeN[2]),
        .line3In(pin[3]), .line3Out(dOut[3]), .line3OeN(dOeN[3]));
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        flip <= ~flip;
        if (norReadCmd === 1'h1)
            norCnt <= norCnt + 1;
        if (txTaken === 1'h1)
            tkCnt <= tkCnt + 1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic check(input string s, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic pop_rx(input logic [7:0] e);
        check("rxValid", 8'h01, {7'h00, rxValid});
        check("rxData", e, rxData);
        rxReady = 1'h1;
        wt(1);
        rxReady = 1'h0;
    endtask
    task automatic wr_lock(input logic [7:0] d, e);
        lockWrData = d;
        lockWrEn = 1'h1;
        wt(1);
        lockWrEn = 1'h0;
        wt(2);
        check("lockReg", e, lockReg);
    endtask
    task automatic complete_run();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        wt(6);
        reset = 1'h0;
        wt(2);
        check("lockReg", 8'h7C, lockReg);
        check("idle", 8'h1F, {3'h0, standby, dOeN});
        internalBusy = 1'h1;
        wt(3);
        check("standby", 8'h00, {7'h00, standby});
        internalBusy = 1'h0;
        clkEnable = 1'h0;
        wr_lock(8'h04, 8'h7C);
        clkEnable = 1'h1;
        wr_lock(8'h81, 8'h80);
        wpN = 1'h0;
        wt(4);
        wr_lock(8'h7E, 8'h82);
        wr_lock(8'h7C, 8'h7C);
        wr_lock(8'h80, 8'h80);
        laneMode = SNB_LANE_QUAD;
        wt(4);
        wr_lock(8'h3C, 8'h3C);
        wpN = 1'h1;
        securityCfg = 3'h5;
        wt(3);
        check("norReadMode", 8'h01, {7'h00, norReadMode});
        laneMode = SNB_LANE_SINGLE;
        foreach (cmds[i]) begin
            host.select(1'h0);
            host.xfer(cmds[i], 1, r);
            host.deselect();
            pop_rx(cmds[i]);
        end
        check("norCnt", 8'h02, norCnt[7:0]);
        pauseEnable = 1'h1;
        for (int w = 2; w <= 4; w += 2) begin
            laneMode = w == 2 ? SNB_LANE_DUAL : SNB_LANE_QUAD;
            host.select(1'h0);
            host.xfer(8'h96, 1, r);
            host.xfer(8'h5A ^ 8'(w), w, r);
            host.deselect();
            pop_rx(8'h96);
            pop_rx(8'h5A ^ 8'(w));
        end
        laneMode = SNB_LANE_SINGLE;
        txEnable = 1'h1;
        host.select(1'h1);
        host.xfer(8'h00, 1, r);
        check("txByte", 8'hC3, r);
        txValid = 1'h0;
        txData = 8'h3C;
        host.xfer(8'h00, 1, r);
        host.deselect();
        txEnable = 1'h0;
        check("txIdle", 8'hFF, r);
        check("txTaken", 8'h01, tkCnt[7:0]);
        pop_rx(8'h00);
        pop_rx(8'h00);
        host.select(1'h0);
        holdN = 1'h0;
        wt(6);
        check("paused", 8'h01, {7'h00, paused});
        host.xfer(8'h00, 1, r);
        holdN = 1'h1;
        host.xfer(8'h3C, 1, r);
        holdN = 1'h0;
        host.deselect();
        check("csReset", 8'h00, {6'h00, paused, selected});
        holdN = 1'h1;
        pop_rx(8'h3C);
        host.select(1'h0);
        for (int i = 0; i < 10; i++)
            host.xfer(8'(i), 1, r);
        wt(4);
        check("rxOverrun", 8'h01, {7'h00, rxOverrun});
        host.deselect();
        check("overClr", 8'h00, {7'h00, rxOverrun});
        for (int i = 0; i < 9; i++)
            pop_rx(i < 8 ? 8'(i) : 8'h09);
        check("rxEmpty", 8'h00, {7'h00, rxValid});
        complete_run();
    end
endmodule
bind snb_bus_interface snb_bus_interface_assertions chk (.*);
`default_nettype wire
